// [hw/peu_pkg.sv]
// constants for the time-event unit index and interrupt status block
package peu_pkg;
    localparam int PEU_ADDR_W = 12;
    localparam logic [11:0] PEU_OFF_INDEX = 12'h520;
    localparam logic [11:0] PEU_OFF_STAT0 = 12'h524;
    localparam logic [11:0] PEU_OFF_STAT1 = 12'h528;
    localparam logic [11:0] PEU_OFF_CTRL = 12'h52c;
    localparam logic [11:0] PEU_OFF_NOTIFY = 12'h5c0;
    localparam int PEU_FIRE_N = 3;
    localparam int PEU_STAMP_N = 2;
    localparam int PEU_BIT_STAMP_SEL = 8;
    localparam int PEU_LSB_FIRE_SEL = 0;
    localparam int PEU_LSB_FIRE_HI = 16;
    localparam int PEU_LSB_FIRE_LO = 0;
    localparam int PEU_LSB_STAMP_IRQ = 0;
    localparam int PEU_BIT_FIRE_EN = 3;
    localparam int PEU_BIT_STAMP_IE = 5;
    localparam logic [1:0] PEU_FIRE_SEL_RSVD = 2'h3;
    localparam logic [1:0] PEU_FIRE_SEL_RST = 2'h0;
    localparam logic PEU_STAMP_SEL_RST = 1'h0;
    localparam logic [2:0] PEU_FIRE_FLAGS_RST = 3'h0;
    localparam logic [1:0] PEU_STAMP_FLAGS_RST = 2'h0;
endpackage

// [hw/peu_core.sv]
// index register, done/error status and interrupt status of the time-event units
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/1ps
module peu_core
    import peu_pkg::*;
(
    input wire logic sys_clk, // 125 MHz core clock
    input wire logic sys_rst, // synchronous reset, active high
    input wire logic [peu_pkg::PEU_ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_writedata, // write data
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic [peu_pkg::PEU_FIRE_N-1:0] fire_done_evt, // fire unit output generated
    input wire logic [peu_pkg::PEU_FIRE_N-1:0] fire_late_evt, // target earlier than system time
    input wire logic [peu_pkg::PEU_STAMP_N-1:0] stamp_evt, // stamp unit interrupt event
    output logic [1:0] fire_unit_select, // fire unit reached by indexed access
    output logic stamp_unit_select, // stamp unit reached by indexed access
    output logic [peu_pkg::PEU_FIRE_N-1:0] fire_enable, // per fire unit enable
    output logic [peu_pkg::PEU_FIRE_N-1:0] fire_notify_on, // per fire unit notify
    output logic [peu_pkg::PEU_STAMP_N-1:0] stamp_irq_enable, // per stamp unit irq enable
    output logic event_irq // global time-event interrupt status
);
    import peu_pkg::*;

    logic ack;
    logic next_ack;
    logic [31:0] next_readdata;
    logic [1:0] next_fire_sel;
    logic next_stamp_sel;
    logic [2:0] done_flag, err_flag, fire_irq;
    logic [2:0] next_done, next_err, next_fire_irq, next_fire_en, next_notify;
    logic [1:0] stamp_irq, next_stamp_irq, next_stamp_ie;
    logic next_event_irq;
    logic wr, wr_index, wr_stat0, wr_stat1, wr_ctrl, wr_notify;
    logic [2:0] en_clear, fire_hit;

    // one wait cycle lets read data come from a flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign wr = avs_write & ack;
    assign wr_index = wr && avs_address == PEU_OFF_INDEX;
    assign wr_stat0 = wr && avs_address == PEU_OFF_STAT0;
    assign wr_stat1 = wr && avs_address == PEU_OFF_STAT1;
    assign wr_ctrl = wr && avs_address == PEU_OFF_CTRL;
    assign wr_notify = wr && avs_address == PEU_OFF_NOTIFY;

    always_comb begin
        next_ack = (avs_read | avs_write) & ~ack;
        next_readdata = avs_readdata;
        if (avs_read && !ack) begin
            next_readdata = 32'h0;
            // reserved read zero
            // zero reserved fields
            unique case (avs_address)
                PEU_OFF_INDEX: begin
                    next_readdata[PEU_BIT_STAMP_SEL] = stamp_unit_select;
                    next_readdata[PEU_LSB_FIRE_SEL +: 2] = fire_unit_select;
                end
                PEU_OFF_STAT0: begin
                    next_readdata[PEU_LSB_FIRE_HI +: 3] = err_flag;
                    next_readdata[PEU_LSB_FIRE_LO +: 3] = done_flag;
                end
                PEU_OFF_STAT1: begin
                    next_readdata[PEU_LSB_FIRE_HI +: 3] = fire_irq;
                    next_readdata[PEU_LSB_STAMP_IRQ +: 2] = stamp_irq;
                end
                PEU_OFF_CTRL: begin
                    next_readdata[PEU_BIT_STAMP_IE] = stamp_irq_enable[stamp_unit_select];
                    next_readdata[PEU_BIT_FIRE_EN] = fire_enable[fire_unit_select];
                end
                PEU_OFF_NOTIFY: begin
                    next_readdata[2:0] = fire_notify_on;
                end
                default: next_readdata = 32'h0;
            endcase
        end
    end

    always_comb begin
        next_stamp_sel = stamp_unit_select;
        next_fire_sel = fire_unit_select;
        next_fire_en = fire_enable;
        next_stamp_ie = stamp_irq_enable;
        next_notify = fire_notify_on;
        en_clear = 3'h0;
        if (wr_index && avs_byteenable[1]) begin
            next_stamp_sel = avs_writedata[PEU_BIT_STAMP_SEL];
        end
        if (wr_index && avs_byteenable[0]
                && avs_writedata[PEU_LSB_FIRE_SEL +: 2] != PEU_FIRE_SEL_RSVD) begin
            next_fire_sel = avs_writedata[PEU_LSB_FIRE_SEL +: 2];
        end
        if (wr_notify && avs_byteenable[0]) begin
            next_notify = avs_writedata[2:0];
        end
        if (wr_ctrl && avs_byteenable[0]) begin
            next_stamp_ie[stamp_unit_select] = avs_writedata[PEU_BIT_STAMP_IE];
            next_fire_en[fire_unit_select] = avs_writedata[PEU_BIT_FIRE_EN];
            en_clear[fire_unit_select] = ~avs_writedata[PEU_BIT_FIRE_EN];
        end
        // enable self-clears once the output is generated
        next_fire_en = next_fire_en & ~fire_done_evt;
    end

    always_comb begin
        fire_hit = (fire_done_evt | fire_late_evt) & fire_notify_on;
        next_done = done_flag;
        next_err = err_flag;
        next_fire_irq = fire_irq;
        next_stamp_irq = stamp_irq;
        if (wr_stat0 && avs_byteenable[0]) begin
            next_done = next_done & ~avs_writedata[PEU_LSB_FIRE_LO +: 3];
        end
        if (wr_stat0 && avs_byteenable[2]) begin
            next_err = next_err & ~avs_writedata[PEU_LSB_FIRE_HI +: 3];
        end
        next_err = next_err & ~en_clear;
        if (wr_stat1 && avs_byteenable[2]) begin
            next_fire_irq = next_fire_irq & ~avs_writedata[PEU_LSB_FIRE_HI +: 3];
        end
        if (wr_stat1 && avs_byteenable[0]) begin
            next_stamp_irq = next_stamp_irq & ~avs_writedata[PEU_LSB_STAMP_IRQ +: 2];
        end
        // sets come last so an event in the clear cycle survives
        // done needs notify
        next_done = next_done | (fire_done_evt & fire_notify_on);
        next_err = next_err | (fire_late_evt & fire_notify_on);
        next_fire_irq = next_fire_irq | fire_hit;
        next_stamp_irq = next_stamp_irq | (stamp_evt & stamp_irq_enable);
        next_event_irq = |{next_fire_irq, next_stamp_irq};
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
            avs_readdata <= 32'h0;
            stamp_unit_select <= PEU_STAMP_SEL_RST;
            fire_unit_select <= PEU_FIRE_SEL_RST;
            fire_enable <= PEU_FIRE_FLAGS_RST;
            fire_notify_on <= PEU_FIRE_FLAGS_RST;
            stamp_irq_enable <= PEU_STAMP_FLAGS_RST;
            done_flag <= PEU_FIRE_FLAGS_RST;
            err_flag <= PEU_FIRE_FLAGS_RST;
            fire_irq <= PEU_FIRE_FLAGS_RST;
            stamp_irq <= PEU_STAMP_FLAGS_RST;
            event_irq <= 1'b0;
        end else begin
            ack <= next_ack;
            avs_readdata <= next_readdata;
            stamp_unit_select <= next_stamp_sel;
            fire_unit_select <= next_fire_sel;
            fire_enable <= next_fire_en;
            fire_notify_on <= next_notify;
            stamp_irq_enable <= next_stamp_ie;
            done_flag <= next_done;
            err_flag <= next_err;
            fire_irq <= next_fire_irq;
            stamp_irq <= next_stamp_irq;
            event_irq <= next_event_irq;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_sel_write;
        wr_index && avs_byteenable[0] && avs_writedata[1:0] != PEU_FIRE_SEL_RSVD;
    endsequence

    sequence s_ctrl_read;
        avs_read && ack && avs_address == PEU_OFF_CTRL;
    endsequence

    sequence s_err_clear;
        wr_stat0 && avs_byteenable[2] && avs_writedata[16] && !fire_late_evt[0];
    endsequence

    // a stamp event while its enable is on
    sequence s_stamp_hit;
        stamp_evt[0] && stamp_irq_enable[0];
    endsequence

    global_or_a: assert property (event_irq == |{fire_irq, stamp_irq})
        else $error("global interrupt differs from status OR");

    fire_sel_a: assert property (s_sel_write |=> fire_unit_select == $past(avs_writedata[1:0]))
        else $error("fire select not taken");

    fire_sel_rsvd_a: assert property (fire_unit_select != PEU_FIRE_SEL_RSVD)
        else $error("fire select holds reserved code");

    stamp_sel_a: assert property (wr_index && avs_byteenable[1]
        |=> stamp_unit_select == $past(avs_writedata[8]))
        else $error("stamp select not taken");

    // event_irq is built from the next flags, so it rises together with them
    err_set_a: assert property (fire_late_evt[1] && fire_notify_on[1]
        |=> err_flag[1] && fire_irq[1] && event_irq)
        else $error("late target did not flag error");

    err_clear_a: assert property (s_err_clear |=> !err_flag[0])
        else $error("error flag not cleared by write one");

    done_set_a: assert property (fire_done_evt[2] && fire_notify_on[2]
        |=> done_flag[2] && !fire_enable[2])
        else $error("done flag or enable wrong after output");

    fire_gate_a: assert property ((fire_irq & ~$past(fire_irq) & ~$past(fire_notify_on)) == 3'h0)
        else $error("fire interrupt set without notify");

    stamp_gate_a: assert property ((stamp_irq & ~$past(stamp_irq) & ~$past(stamp_irq_enable)) == 2'h0)
        else $error("stamp interrupt set without enable");

    irq_clear_a: assert property (wr_stat1 && avs_byteenable[0] && avs_writedata[0]
        && !stamp_evt[0] |=> !stamp_irq[0])
        else $error("stamp interrupt not cleared");

    ctrl_route_a: assert property (s_ctrl_read
        |-> avs_readdata[5] == $past(stamp_irq_enable[stamp_unit_select]))
        else $error("control read not from selected stamp unit");

    index_rsvd_a: assert property (avs_read && ack && avs_address == PEU_OFF_INDEX
        |-> avs_readdata[31:9] == 23'h0 && avs_readdata[7:2] == 6'h0)
        else $error("reserved index bits not zero");

    stat0_rsvd_a: assert property (avs_read && ack && avs_address == PEU_OFF_STAT0
        |-> avs_readdata[31:19] == 13'h0 && avs_readdata[15:3] == 13'h0)
        else $error("reserved done/error bits not zero");

    stat1_rsvd_a: assert property (avs_read && ack && avs_address == PEU_OFF_STAT1
        |-> avs_readdata[31:19] == 13'h0 && avs_readdata[15:2] == 14'h0)
        else $error("reserved interrupt status bits not zero");

    done_clear_a: assert property (wr_stat0 && avs_byteenable[0] && avs_writedata[0]
        && !fire_done_evt[0] |=> !done_flag[0])
        else $error("done flag not cleared by write one");

    // clearing the enable must drop the error even without a status write
    en_clear_err_a: assert property (wr_ctrl && avs_byteenable[0] && !avs_writedata[3]
        && fire_unit_select == 2'h1 && !fire_late_evt[1] |=> !err_flag[1])
        else $error("error flag not cleared by enable clear");

    err_gate_a: assert property ((err_flag & ~$past(err_flag) & ~$past(fire_notify_on)) == 3'h0)
        else $error("error flag set without notify");

    done_gate_a: assert property ((done_flag & ~$past(done_flag) & ~$past(fire_notify_on)) == 3'h0)
        else $error("done flag set without notify");

    fire_irq_clear_a: assert property (wr_stat1 && avs_byteenable[2] && avs_writedata[16]
        && !fire_hit[0] |=> !fire_irq[0])
        else $error("fire interrupt not cleared");

    stamp_set_a: assert property (stamp_evt[1] && stamp_irq_enable[1]
        |=> stamp_irq[1])
        else $error("enabled stamp event lost");

    stamp_irq_global_a: assert property (s_stamp_hit |=> stamp_irq[0] && event_irq)
        else $error("stamp event did not reach global interrupt");

    ctrl_stamp_wr_a: assert property (wr_ctrl && avs_byteenable[0] && stamp_unit_select
        |=> stamp_irq_enable[1] == $past(avs_writedata[5]))
        else $error("stamp enable not written to selected unit");

    // the done event self-clears the enable, so leave that cycle out
    fire_route_a: assert property (wr_ctrl && avs_byteenable[0] && fire_unit_select == 2'h1
        && !fire_done_evt[1] |=> fire_enable[1] == $past(avs_writedata[3]))
        else $error("fire enable not written to selected unit");

    sel_hold_a: assert property (!wr_index
        |=> $stable(fire_unit_select) && $stable(stamp_unit_select))
        else $error("unit select changed without index write");

    // exactly one wait state: the master never stalls twice
    wait_once_a: assert property ((avs_read || avs_write) && !ack
        |=> !avs_waitrequest)
        else $error("second wait state inserted");

    notify_rd_a: assert property (avs_read && ack && avs_address == PEU_OFF_NOTIFY
        |-> avs_readdata[31:3] == 29'h0 && avs_readdata[2:0] == $past(fire_notify_on))
        else $error("notify read wrong");

    bus_answer_a: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
        else $error("bus request not answered in time");
endmodule

// [testbench/ptp_event_unit_index_and_irq_status_bench.sv]
// self-checking bench for the time-event index and interrupt status block
`timescale 1ns/1ps
module ptp_event_unit_index_and_irq_status_bench;
    import peu_pkg::*;
    logic sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest, stamp_unit_select, event_irq;
    logic [PEU_ADDR_W-1:0] avs_address;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic [PEU_FIRE_N-1:0] fire_done_evt, fire_late_evt, fire_enable, fire_notify_on;
    logic [PEU_STAMP_N-1:0] stamp_evt, stamp_irq_enable;
    logic [1:0] fire_unit_select;
    int errors, cmp_count;

    peu_core DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fire_done_evt(fire_done_evt),
        .fire_late_evt(fire_late_evt), .stamp_evt(stamp_evt),
        .fire_unit_select(fire_unit_select), .stamp_unit_select(stamp_unit_select),
        .fire_enable(fire_enable), .fire_notify_on(fire_notify_on),
        .stamp_irq_enable(stamp_irq_enable), .event_irq(event_irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // the slave may stall; give up after a bounded wait so a hang is reported
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) check("waitrequest", {31'h0, avs_waitrequest}, 32'h0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        wait_ack();
        avs_write <= 1'b0;
        // let the registers written at this edge settle before any direct check
        @(negedge sys_clk);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        @(posedge sys_clk);
        avs_read <= 1'b1;
        avs_address <= a;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
        check(name, d, exp);
    endtask

    // one-cycle event pulses, then one edge so the flags are visible
    task automatic pulse(input logic [2:0] done, input logic [2:0] late, input logic [1:0] st);
        @(posedge sys_clk);
        fire_done_evt <= done;
        fire_late_evt <= late;
        stamp_evt <= st;
        @(posedge sys_clk);
        fire_done_evt <= 3'h0;
        fire_late_evt <= 3'h0;
        stamp_evt <= 2'h0;
        @(posedge sys_clk);
    endtask

    task automatic irq_chk(input logic exp);
        @(posedge sys_clk);
        check("event_irq", {31'h0, event_irq}, {31'h0, exp});
    endtask

    initial begin
        #60000;
        errors++;
        $display("ERROR watchdog expected finish seen timeout");
        print_verdict();
    end

    initial begin
        {avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
        {fire_done_evt, fire_late_evt, stamp_evt} = '0;
        sys_rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rchk(PEU_OFF_INDEX, 32'h0, "index reset");
        rchk(PEU_OFF_STAT0, 32'h0, "stat0 reset");
        rchk(PEU_OFF_STAT1, 32'h0, "stat1 reset");
        for (int c = 0; c < 3; c++) begin
            wr(PEU_OFF_INDEX, 32'(c), 4'hf);
            check("fire_unit_select", {30'h0, fire_unit_select}, 32'(c));
        end
        wr(PEU_OFF_INDEX, 32'hffff_ff02, 4'hf);
        rchk(PEU_OFF_INDEX, 32'h0000_0102, "index reserved");
        check("stamp_unit_select", {31'h0, stamp_unit_select}, 32'h1);
        wr(PEU_OFF_INDEX, 32'h0000_0103, 4'hf);
        rchk(PEU_OFF_INDEX, 32'h0000_0102, "fire code 3");
        wr(PEU_OFF_INDEX, 32'h0000_0000, 4'h1);
        rchk(PEU_OFF_INDEX, 32'h0000_0100, "lane gating");
        rchk(12'h600, 32'h0, "unmapped");
        // notify off: events must leave every flag clear
        pulse(3'h7, 3'h7, 2'h3);
        rchk(PEU_OFF_STAT0, 32'h0, "stat0 no notify");
        rchk(PEU_OFF_STAT1, 32'h0, "stat1 gated");
        irq_chk(1'b0);
        wr(PEU_OFF_NOTIFY, 32'h7, 4'hf);
        check("fire_notify_on", {29'h0, fire_notify_on}, 32'h7);
        rchk(PEU_OFF_NOTIFY, 32'h7, "notify read");
        pulse(3'h5, 3'h0, 2'h0);
        rchk(PEU_OFF_STAT0, 32'h0000_0005, "done set");
        rchk(PEU_OFF_STAT1, 32'h0005_0000, "fire irq set");
        irq_chk(1'b1);
        wr(PEU_OFF_STAT0, 32'h0000_0001, 4'hf);
        rchk(PEU_OFF_STAT0, 32'h0000_0004, "done w1c");
        wr(PEU_OFF_STAT1, 32'h0001_0000, 4'hf);
        irq_chk(1'b1);
        wr(PEU_OFF_STAT1, 32'h0004_0000, 4'hf);
        irq_chk(1'b0);
        wr(PEU_OFF_STAT0, 32'hffff_ffff, 4'hf);
        pulse(3'h0, 3'h2, 2'h0);
        rchk(PEU_OFF_STAT0, 32'h0002_0000, "late error");
        rchk(PEU_OFF_STAT1, 32'h0002_0000, "late irq");
        wr(PEU_OFF_INDEX, 32'h0000_0001, 4'hf);
        wr(PEU_OFF_CTRL, 32'h0000_0008, 4'hf);
        check("fire_enable", {29'h0, fire_enable}, 32'h2);
        wr(PEU_OFF_CTRL, 32'h0000_0000, 4'hf);
        rchk(PEU_OFF_STAT0, 32'h0, "error by enable");
        wr(PEU_OFF_STAT1, 32'h0002_0000, 4'hf);
        rchk(PEU_OFF_STAT1, 32'h0, "irq w1c");
        irq_chk(1'b0);
        pulse(3'h0, 3'h1, 2'h0);
        wr(PEU_OFF_STAT0, 32'h0001_0000, 4'hf);
        rchk(PEU_OFF_STAT0, 32'h0, "error w1c");
        wr(PEU_OFF_STAT1, 32'hffff_ffff, 4'hf);
        wr(PEU_OFF_INDEX, 32'h0000_0100, 4'hf);
        wr(PEU_OFF_CTRL, 32'h0000_0020, 4'hf);
        check("stamp_irq_enable", {30'h0, stamp_irq_enable}, 32'h2);
        rchk(PEU_OFF_CTRL, 32'h0000_0020, "ctrl indexed read");
        pulse(3'h0, 3'h0, 2'h3);
        rchk(PEU_OFF_STAT1, 32'h0000_0002, "stamp irq");
        irq_chk(1'b1);
        wr(PEU_OFF_STAT1, 32'h0000_0002, 4'hf);
        rchk(PEU_OFF_STAT1, 32'h0, "stamp w1c");
        irq_chk(1'b0);
        print_verdict();
    end
endmodule
